// File: bench/crr_host.sv
// management bus host model issuing decoded requests as one-cycle pulses
// assumes the bench samples answers 1 ns after the taking edge
`timescale 1ns/1ns
`default_nettype none
module crr_host (
  input  wire logic  mclk,
  output logic       wr_valid,
  output logic [7:0] wr_cmd,
  output logic [1:0] wr_type,
  output logic [15:0] wr_data,
  output logic       wr_pec_present,
  output logic       wr_pec_ok,
  output logic       rd_valid,
  output logic [7:0] rd_cmd,
  output logic [1:0] rd_type
);
  initial begin
    {wr_valid, wr_cmd, wr_type, wr_data, wr_pec_present, wr_pec_ok, rd_valid, rd_cmd, rd_type} = '0;
  end
  // byte, word or block type per register is chosen by the caller
  task automatic wr(input logic [7:0] c, input logic [1:0] t, input logic [15:0] d,
                    input logic [1:0] pk);
    @(posedge mclk);
    wr_valid <= 1'b1;
    wr_cmd   <= c;
    wr_type  <= t;
    wr_data  <= d;
    {wr_pec_present, wr_pec_ok} <= pk;
    @(posedge mclk);
    wr_valid <= 1'b0;
    wr_data  <= ~d;
  endtask
  task automatic rd(input logic [7:0] c, input logic [1:0] t);
    @(posedge mclk);
    rd_valid <= 1'b1;
    rd_cmd   <= c;
    rd_type  <= t;
    @(posedge mclk);
    rd_valid <= 1'b0;
    rd_cmd   <= ~c;
  endtask
endmodule
`default_nettype wire

// File: bench/crr_regs_props.sv
// checker on the ports of the option and remote control register block
// assumes it is bound onto every crr_regs instance
`timescale 1ns/1ns
`default_nettype none
module crr_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        wr_valid,
  input wire logic [7:0]  wr_cmd,
  input wire logic [1:0]  wr_type,
  input wire logic [15:0] wr_data,
  input wire logic        wr_pec_present,
  input wire logic        wr_pec_ok,
  input wire logic        rd_valid,
  input wire logic [7:0]  rd_cmd,
  input wire logic [1:0]  rd_type,
  input wire logic [15:0] temp_offset_int,
  input wire logic [31:0] temp_cal,
  input wire logic        rd_ack,
  input wire logic        rd_err,
  input wire logic [31:0] rd_data,
  input wire logic [2:0]  rd_len,
  input wire logic        wr_ack,
  input wire logic        wr_err,
  input wire logic        pec_required
);
  // ---------
  // properties
  // ---------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_rd_ans; rd_valid |=> rd_ack; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_wr_ans; wr_valid |=> wr_ack != wr_err; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer wrong");
  property p_cal;
    rd_valid && rd_cmd == 8'he2 && rd_type == 2'h2 |=> rd_data == $past(temp_cal) && rd_len == 3'h4;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration read wrong");
  property p_toff;
    rd_valid && rd_cmd == 8'he1 && rd_type == 2'h1 |=>
      rd_data[15:0] == $past(temp_offset_int) && rd_len == 3'h2;
  endproperty
  a_toff: assert property (p_toff) else $error("offset read wrong");
  property p_rsvd; rd_valid && rd_cmd == 8'he0 && rd_type == 2'h0 |=> rd_data[1:0] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_ro; wr_valid && (wr_cmd == 8'he1 || wr_cmd == 8'he2) |=> wr_err; endproperty
  a_ro: assert property (p_ro) else $error("read-only write taken");
  property p_pec;
    wr_valid && pec_required && !$past(wr_valid) && !(wr_pec_present && wr_pec_ok) |=> wr_err;
  endproperty
  a_pec: assert property (p_pec) else $error("unchecked write taken");
  property p_pec_bit;
    wr_valid && wr_cmd == 8'he0 && wr_type == 2'h0 ##1 wr_ack |=> pec_required == $past(wr_data[7], 2);
  endproperty
  a_pec_bit: assert property (p_pec_bit) else $error("check flag wrong");
  c_cal: cover property (rd_valid && rd_cmd == 8'he2 ##1 rd_ack);
  c_refuse: cover property (pec_required && wr_valid ##1 wr_err);
  c_accept: cover property (pec_required && wr_valid ##1 wr_ack);
endmodule
bind crr_regs crr_props u_props (
  .mclk            (mclk),
  .reset           (reset),
  .wr_valid        (wr_valid),
  .wr_cmd          (wr_cmd),
  .wr_type         (wr_type),
  .wr_data         (wr_data),
  .wr_pec_present  (wr_pec_present),
  .wr_pec_ok       (wr_pec_ok),
  .rd_valid        (rd_valid),
  .rd_cmd          (rd_cmd),
  .rd_type         (rd_type),
  .temp_offset_int (temp_offset_int),
  .temp_cal        (temp_cal),
  .rd_ack          (rd_ack),
  .rd_err          (rd_err),
  .rd_data         (rd_data),
  .rd_len          (rd_len),
  .wr_ack          (wr_ack),
  .wr_err          (wr_err),
  .pec_required    (pec_required)
);
`default_nettype wire

// File: bench/crr_regs_tb.sv
// self-checking bench for the option and remote control register block
// assumes crr_regs, crr_host and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module crr_regs_tb;
  logic        mclk = 1'b0, reset = 1'b1, remote_pin = 1'b0, ctrl_pin_on = 1'b0, operation_on = 1'b0;
  logic        wr_valid, wr_pec_present, wr_pec_ok, rd_valid, rd_ack, rd_err, wr_ack, wr_err;
  logic        pec_required, hybrid_ratio_regulation, hybrid_ratio_active, droop_slope_select;
  logic        adaptive_ramp_loop_comp, dynamic_bus_voltage_enable, output_on, quick_off, soft_stop;
  logic        pa, on;
  logic [4:0]  cfg;
  logic [7:0]  wr_cmd, rd_cmd;
  logic [1:0]  wr_type, rd_type;
  logic [2:0]  rd_len;
  logic [15:0] wr_data, temp_offset_int = 16'h1234, vin_reading = 16'h00ff;
  logic [31:0] temp_cal = 32'h5a6b7c8d, rd_data;
  int          miscompares = 0, samples_checked = 0;
  crr_regs DUT (
    .mclk                       (mclk),
    .reset                      (reset),
    .wr_valid                   (wr_valid),
    .wr_cmd                     (wr_cmd),
    .wr_type                    (wr_type),
    .wr_data                    (wr_data),
    .wr_pec_present             (wr_pec_present),
    .wr_pec_ok                  (wr_pec_ok),
    .rd_valid                   (rd_valid),
    .rd_cmd                     (rd_cmd),
    .rd_type                    (rd_type),
    .temp_offset_int            (temp_offset_int),
    .temp_cal                   (temp_cal),
    .vin_reading                (vin_reading),
    .remote_pin                 (remote_pin),
    .ctrl_pin_on                (ctrl_pin_on),
    .operation_on               (operation_on),
    .rd_ack                     (rd_ack),
    .rd_err                     (rd_err),
    .rd_data                    (rd_data),
    .rd_len                     (rd_len),
    .wr_ack                     (wr_ack),
    .wr_err                     (wr_err),
    .pec_required               (pec_required),
    .hybrid_ratio_regulation    (hybrid_ratio_regulation),
    .hybrid_ratio_active        (hybrid_ratio_active),
    .droop_slope_select         (droop_slope_select),
    .adaptive_ramp_loop_comp    (adaptive_ramp_loop_comp),
    .dynamic_bus_voltage_enable (dynamic_bus_voltage_enable),
    .output_on                  (output_on),
    .quick_off                  (quick_off),
    .soft_stop                  (soft_stop)
  );
  crr_host host (
    .mclk           (mclk),
    .wr_valid       (wr_valid),
    .wr_cmd         (wr_cmd),
    .wr_type        (wr_type),
    .wr_data        (wr_data),
    .wr_pec_present (wr_pec_present),
    .wr_pec_ok      (wr_pec_ok),
    .rd_valid       (rd_valid),
    .rd_cmd         (rd_cmd),
    .rd_type        (rd_type)
  );
  always #5 mclk = ~mclk;
  // ---------
  // tasks and tests
  // ---------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [1:0] t, input logic [15:0] d,
                    input logic [1:0] pk, input logic ok);
    host.wr(c, t, d, pk);
    #1 chk({wr_ack, wr_err}, {ok, !ok});
  endtask
  task automatic rd(input logic [7:0] c, input logic [1:0] t, input logic [31:0] e,
                    input logic [2:0] n);
    host.rd(c, t);
    #1 chk({rd_ack, rd_err, rd_len, rd_data}, {1'b1, n == 3'h0, n, e});
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd(8'he0, 2'h0, 32'h0, 3'h1);
    rd(8'he3, 2'h0, 32'h4, 3'h1);
    rd(8'h10, 2'h0, 32'h0, 3'h0);
    rd(8'he3, 2'h1, 32'h0, 3'h0);
    rd(8'he1, 2'h1, 32'h1234, 3'h2);
    rd(8'he2, 2'h2, 32'h5a6b7c8d, 3'h4);
    wr(8'he1, 2'h1, 16'h0001, 2'h3, 1'b0);
    wr(8'he2, 2'h2, 16'h0001, 2'h3, 1'b0);
    wr(8'h58, 2'h1, 16'h0100, 2'h3, 1'b1);
    rd(8'h58, 2'h1, 32'h00000100, 3'h2);
    wr(8'he0, 2'h1, 16'h00ff, 2'h3, 1'h0);
    rd(8'he0, 2'h0, 32'h00000000, 3'h1);
    wr(8'he0, 2'h0, 16'h00ff, 2'h0, 1'b1);
    settle;
    chk({pec_required, hybrid_ratio_regulation, droop_slope_select, adaptive_ramp_loop_comp,
         dynamic_bus_voltage_enable, hybrid_ratio_active}, 6'h3f);
    rd(8'he0, 2'h0, 32'hec, 3'h1);
    @(posedge mclk);
    vin_reading <= 16'h0100;
    settle;
    chk(hybrid_ratio_active, 1'b0);
    wr(8'he3, 2'h0, 16'h0000, 2'h2, 1'b0);
    wr(8'he3, 2'h0, 16'h0000, 2'h0, 1'b0);
    rd(8'he3, 2'h0, 32'h4, 3'h1);
    for (int i = 0; i < 16; i++) begin
      cfg = {i[3], 1'b0, i[2:0]};
      wr(8'he3, 2'h0, {11'h0, cfg}, 2'h3, 1'b1);
      for (int j = 0; j < 8; j++) begin
        @(posedge mclk);
        {remote_pin, ctrl_pin_on, operation_on} <= j[2:0];
        settle;
        pa = cfg[2] && (j[2] == cfg[1]);
        on = !cfg[2] ? j[1] && j[0] : cfg[4] ? pa && j[1] && j[0] : pa || (j[1] && j[0]);
        chk({output_on, quick_off, soft_stop}, {on, !on && cfg[0], !on && !cfg[0]});
      end
    end
    wr(8'he0, 2'h0, 16'h0028, 2'h3, 1'b1);
    wr(8'he3, 2'h0, 16'h0004, 2'h0, 1'b1);
    settle;
    chk({pec_required, hybrid_ratio_regulation, droop_slope_select, adaptive_ramp_loop_comp,
         dynamic_bus_voltage_enable, hybrid_ratio_active}, 6'h0c);
    rd(8'he0, 2'h0, 32'h00000028, 3'h1);
    conclude;
  end
  initial begin
    #100000;
    miscompares++;
    conclude;
  end
endmodule
`default_nettype wire

// File: design/crr_pkg.sv
// package of offsets, field positions and reset values for the option/remote regs
// assumes a byte-oriented management bus front end decodes commands before this block
package crr_pkg;
  localparam logic [7:0] CMD_SPECIAL_OPTION_CONFIG  = 8'he0;
  localparam logic [7:0] CMD_INTERNAL_TEMP_OFFSET   = 8'he1;
  localparam logic [7:0] CMD_EXTERNAL_TEMP_CAL      = 8'he2;
  localparam logic [7:0] CMD_PRIMARY_REMOTE_CFG     = 8'he3;
  localparam logic [7:0] CMD_VIN_UV_WARN_LIMIT      = 8'h58;
  localparam int         BIT_REQUIRE_PEC            = 7;
  localparam int         BIT_HYBRID_RATIO           = 6;
  localparam int         BIT_DROOP_SLOPE            = 5;
  localparam int         BIT_ADAPTIVE_RAMP          = 3;
  localparam int         BIT_DYN_BUS_VOLTAGE        = 2;
  localparam int         BIT_RC_COMBINE_AND         = 4;
  localparam int         BIT_RC_PIN_ENABLE          = 2;
  localparam int         BIT_RC_ACTIVE_HIGH         = 1;
  localparam int         BIT_RC_QUICK_OFF           = 0;
  localparam logic [7:0] SPECIAL_OPTION_WMASK       = 8'hec;
  localparam logic [7:0] REMOTE_CFG_WMASK           = 8'h17;
  localparam logic [7:0] SPECIAL_OPTION_RESET       = 8'h00;
  localparam logic [7:0] REMOTE_CFG_RESET           = 8'h04;
  localparam logic [15:0] VIN_UV_WARN_RESET         = 16'h0000;
  localparam logic [1:0] XFER_BYTE                  = 2'h0;
  localparam logic [1:0] XFER_WORD                  = 2'h1;
  localparam logic [1:0] XFER_BLOCK                 = 2'h2;
endpackage

// File: design/crr_regs.sv
// option and remote on/off configuration registers with on/off decision logic
// assumes a bus front end delivering decoded command writes and read requests,
// synchronous to mclk, with its own packet error check result per write
//
// Contract
// (RULE1) option bit 7 requires packet error check on bus transactions
// (RULE2) option bit 6 enables hybrid ratio regulation for duty headroom
// (RULE3) hybrid ratio: output tracks input ratio below undervoltage warning threshold
// (RULE4) option bit 5 selects linear (0) or non-linear (1) droop
// (RULE5) option bit 3 enables adaptive ramp time and dynamic loop compensation
// (RULE6) option bit 2 enables dynamic bus voltage operation
// (RULE7) option bits 0 and 1 reserved, no function
// (RULE8) internal temperature offset is read-only 16-bit word, 0.1 C units
// (RULE9) calibration read-only four-byte block: bytes 0-1 offset, 2-3 slope
// (RULE10) remote config bit 4: 0 ORs pin with operation/control, 1 ANDs
// (RULE11) remote config bit 2 enables primary remote pin, else ignored
// (RULE12) remote config bit 1 sets pin polarity: 0 low, 1 high active
// (RULE13) remote config bit 0: 0 soft-stop ramp down, 1 quick off
// (RULE14) host uses byte access for configs, word and block reads
// (RULE15) with check required, writes lacking a correct check byte are dropped
`timescale 1ns/1ns
`default_nettype none
module crr_regs (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_cmd,
  input  wire logic [1:0]  wr_type,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_pec_present,
  input  wire logic        wr_pec_ok,
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_cmd,
  input  wire logic [1:0]  rd_type,
  input  wire logic [15:0] temp_offset_int,
  input  wire logic [31:0] temp_cal,
  input  wire logic [15:0] vin_reading,
  input  wire logic        remote_pin,
  input  wire logic        ctrl_pin_on,
  input  wire logic        operation_on,
  output logic             rd_ack,
  output logic             rd_err,
  output logic [31:0]      rd_data,
  output logic [2:0]       rd_len,
  output logic             wr_ack,
  output logic             wr_err,
  output logic             pec_required,
  output logic             hybrid_ratio_regulation,
  output logic             hybrid_ratio_active,
  output logic             droop_slope_select,
  output logic             adaptive_ramp_loop_comp,
  output logic             dynamic_bus_voltage_enable,
  output logic             output_on,
  output logic             quick_off,
  output logic             soft_stop
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]  special_option_config_ff, nxt_special_option_config;
  logic [7:0]  primary_remote_pin_config_ff, nxt_primary_remote_pin_config;
  logic [15:0] vin_uv_warn_ff, nxt_vin_uv_warn;
  logic        rd_ack_ff, nxt_rd_ack;
  logic        rd_err_ff, nxt_rd_err;
  logic [31:0] rd_data_ff, nxt_rd_data;
  logic [2:0]  rd_len_ff, nxt_rd_len;
  logic        wr_ack_ff, nxt_wr_ack;
  logic        wr_err_ff, nxt_wr_err;
  logic        wr_allowed;

  always_comb begin
    wr_allowed = ~special_option_config_ff[crr_pkg::BIT_REQUIRE_PEC] |
                 (wr_pec_present & wr_pec_ok); // RULE1 RULE15
    nxt_special_option_config     = special_option_config_ff;
    nxt_primary_remote_pin_config = primary_remote_pin_config_ff;
    nxt_vin_uv_warn               = vin_uv_warn_ff;
    nxt_wr_ack                    = 1'b0;
    nxt_wr_err                    = 1'b0;
    if (wr_valid) begin
      nxt_wr_err = 1'b1;
      if (wr_allowed) begin
        case (wr_cmd)
          crr_pkg::CMD_SPECIAL_OPTION_CONFIG: begin
            if (wr_type == crr_pkg::XFER_BYTE) begin // RULE14
              nxt_special_option_config = wr_data[7:0] & crr_pkg::SPECIAL_OPTION_WMASK; // RULE7
              nxt_wr_err = 1'b0;
            end
          end
          crr_pkg::CMD_PRIMARY_REMOTE_CFG: begin
            if (wr_type == crr_pkg::XFER_BYTE) begin // RULE14
              nxt_primary_remote_pin_config = wr_data[7:0] & crr_pkg::REMOTE_CFG_WMASK;
              nxt_wr_err = 1'b0;
            end
          end
          crr_pkg::CMD_VIN_UV_WARN_LIMIT: begin
            if (wr_type == crr_pkg::XFER_WORD) begin
              nxt_vin_uv_warn = wr_data; // RULE3
              nxt_wr_err = 1'b0;
            end
          end
          default: begin
            nxt_wr_err = 1'b1; // RULE8 RULE9
          end
        endcase
      end
      nxt_wr_ack = ~nxt_wr_err;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rd_ack  = 1'b0;
    nxt_rd_err  = 1'b0;
    nxt_rd_data = 32'h00000000;
    nxt_rd_len  = 3'h0;
    if (rd_valid) begin
      nxt_rd_ack = 1'b1;
      case (rd_cmd)
        crr_pkg::CMD_SPECIAL_OPTION_CONFIG: begin
          nxt_rd_err  = (rd_type != crr_pkg::XFER_BYTE); // RULE14
          nxt_rd_data = {24'h000000, special_option_config_ff};
          nxt_rd_len  = 3'h1;
        end
        crr_pkg::CMD_INTERNAL_TEMP_OFFSET: begin
          nxt_rd_err  = (rd_type != crr_pkg::XFER_WORD);
          nxt_rd_data = {16'h0000, temp_offset_int}; // RULE8
          nxt_rd_len  = 3'h2;
        end
        crr_pkg::CMD_EXTERNAL_TEMP_CAL: begin
          nxt_rd_err  = (rd_type != crr_pkg::XFER_BLOCK);
          nxt_rd_data = temp_cal; // RULE9
          nxt_rd_len  = 3'h4;
        end
        crr_pkg::CMD_PRIMARY_REMOTE_CFG: begin
          nxt_rd_err  = (rd_type != crr_pkg::XFER_BYTE); // RULE14
          nxt_rd_data = {24'h000000, primary_remote_pin_config_ff};
          nxt_rd_len  = 3'h1;
        end
        crr_pkg::CMD_VIN_UV_WARN_LIMIT: begin
          nxt_rd_err  = (rd_type != crr_pkg::XFER_WORD);
          nxt_rd_data = {16'h0000, vin_uv_warn_ff};
          nxt_rd_len  = 3'h2;
        end
        default: begin
          nxt_rd_err = 1'b1;
        end
      endcase
      if (nxt_rd_err) begin
        nxt_rd_data = 32'h00000000;
        nxt_rd_len  = 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // option and remote decision outputs
  // ----------------------------------------------------------------
  logic nxt_pec_required, pec_required_ff;
  logic nxt_hybrid_ratio, hybrid_ratio_ff, nxt_hybrid_active, hybrid_active_ff;
  logic nxt_droop, droop_ff, nxt_adaptive_ramp, adaptive_ramp_ff, nxt_dyn_bus, dyn_bus_ff;
  logic nxt_on, on_ff, nxt_quick, quick_ff, nxt_soft, soft_ff;
  logic pin_active, pin_term, rc_on;

  always_comb begin
    nxt_pec_required = special_option_config_ff[crr_pkg::BIT_REQUIRE_PEC]; // RULE1
    nxt_hybrid_ratio  = special_option_config_ff[crr_pkg::BIT_HYBRID_RATIO]; // RULE2
    nxt_hybrid_active = nxt_hybrid_ratio & (vin_reading < vin_uv_warn_ff); // RULE3
    nxt_droop         = special_option_config_ff[crr_pkg::BIT_DROOP_SLOPE]; // RULE4
    nxt_adaptive_ramp = special_option_config_ff[crr_pkg::BIT_ADAPTIVE_RAMP]; // RULE5
    nxt_dyn_bus       = special_option_config_ff[crr_pkg::BIT_DYN_BUS_VOLTAGE]; // RULE6
    pin_active = primary_remote_pin_config_ff[crr_pkg::BIT_RC_ACTIVE_HIGH] ?
                 remote_pin : ~remote_pin; // RULE12
    if (!primary_remote_pin_config_ff[crr_pkg::BIT_RC_PIN_ENABLE]) begin
      rc_on = operation_on & ctrl_pin_on; // RULE11
    end else if (primary_remote_pin_config_ff[crr_pkg::BIT_RC_COMBINE_AND]) begin
      rc_on = pin_active & operation_on & ctrl_pin_on; // RULE10
    end else begin
      rc_on = pin_active | (operation_on & ctrl_pin_on); // RULE10
    end
    pin_term  = primary_remote_pin_config_ff[crr_pkg::BIT_RC_QUICK_OFF];
    nxt_on    = rc_on;
    nxt_quick = ~rc_on & pin_term; // RULE13
    nxt_soft  = ~rc_on & ~pin_term; // RULE13
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      special_option_config_ff     <= crr_pkg::SPECIAL_OPTION_RESET;
      primary_remote_pin_config_ff <= crr_pkg::REMOTE_CFG_RESET;
      vin_uv_warn_ff               <= crr_pkg::VIN_UV_WARN_RESET;
      rd_ack_ff  <= 1'b0;
      rd_err_ff  <= 1'b0;
      rd_data_ff <= 32'h00000000;
      rd_len_ff  <= 3'h0;
      wr_ack_ff  <= 1'b0;
      wr_err_ff  <= 1'b0;
      pec_required_ff <= 1'b0;
      hybrid_ratio_ff  <= 1'h0;
      hybrid_active_ff <= 1'h0;
      droop_ff         <= 1'h0;
      adaptive_ramp_ff <= 1'h0;
      dyn_bus_ff       <= 1'h0;
      on_ff      <= 1'b0;
      quick_ff   <= 1'b0;
      soft_ff    <= 1'b0;
    end else begin
      special_option_config_ff     <= nxt_special_option_config;
      primary_remote_pin_config_ff <= nxt_primary_remote_pin_config;
      vin_uv_warn_ff               <= nxt_vin_uv_warn;
      rd_ack_ff  <= nxt_rd_ack;
      rd_err_ff  <= nxt_rd_err;
      rd_data_ff <= nxt_rd_data;
      rd_len_ff  <= nxt_rd_len;
      wr_ack_ff  <= nxt_wr_ack;
      wr_err_ff  <= nxt_wr_err;
      pec_required_ff <= nxt_pec_required;
      hybrid_ratio_ff  <= nxt_hybrid_ratio;
      hybrid_active_ff <= nxt_hybrid_active;
      droop_ff         <= nxt_droop;
      adaptive_ramp_ff <= nxt_adaptive_ramp;
      dyn_bus_ff       <= nxt_dyn_bus;
      on_ff      <= nxt_on;
      quick_ff   <= nxt_quick;
      soft_ff    <= nxt_soft;
    end
  end

  assign rd_ack  = rd_ack_ff;
  assign rd_err  = rd_err_ff;
  assign rd_data = rd_data_ff;
  assign rd_len  = rd_len_ff;
  assign wr_ack  = wr_ack_ff;
  assign wr_err  = wr_err_ff;
  assign pec_required               = pec_required_ff;
  assign hybrid_ratio_regulation    = hybrid_ratio_ff;
  assign hybrid_ratio_active        = hybrid_active_ff;
  assign droop_slope_select         = droop_ff;
  assign adaptive_ramp_loop_comp    = adaptive_ramp_ff;
  assign dynamic_bus_voltage_enable = dyn_bus_ff;
  assign output_on                  = on_ff;
  assign quick_off                  = quick_ff;
  assign soft_stop                  = soft_ff;
endmodule
`default_nettype wire
